/* core/adcseq_pkg.sv */
// Purpose: constants for the conversion sequencer
// Assumes: APB, 32-bit data, 125 MHz pclk
// Notes:   one word per register
//
// What this block does
// - sampling takes 4 A/D clocks, conversion 12, total 16.
// - a start bit pulse low-high-low launches a conversion.
// - busy high during conversion; results valid once it falls.
// - conversion runs in hardware; bus never stalls.
// - power enable cleared switches converter off.
// - external source connects the selected external channel while channel select bit 3 is clear.
// - reference select picks converter reference; software handles pin sharing.
// - format bit selects alignment of the 12-bit result.
// - results are 12 bits, full scale all ones.
// - divider code n divides the system clock by two to the n.
// - completion sets request flag; flag with local and global enables raises interrupt.
// - source 001 bandgap, 010-100 ground, else external channel.
package adcseq_pkg;
    localparam logic [11:0] ADDR_CTRL_A   = 12'h000;
    localparam logic [11:0] ADDR_CTRL_B   = 12'h004;
    localparam logic [11:0] ADDR_RES_HIGH = 12'h008;
    localparam logic [11:0] ADDR_RES_LOW  = 12'h00C;
    localparam logic [11:0] ADDR_INT_STAT = 12'h010;
    localparam logic [11:0] ADDR_INT_MASK = 12'h014;
    // control a fields
    localparam int CA_CHAN_LSB  = 0;   // channel_sel [3:0]
    localparam int CA_FORMAT    = 4;   // result_format_sel
    localparam int CA_POWER     = 5;
    localparam int CA_BUSY      = 6;   // read only
    localparam int CA_START     = 7;
    // control b fields
    localparam int CB_DIV_LSB   = 0;   // adc_clock_divider_sel [2:0]
    localparam int CB_REF_LSB   = 3;   // reference_source_sel [1:0]
    localparam int CB_SRC_LSB   = 5;   // input_source_sel [2:0]
    // interrupt fields
    localparam int IS_DONE      = 0;
    localparam int IS_GLOBAL    = 1;   // mask reg: global enable
    localparam int SAMPLE_CYC   = 4;
    localparam int CONVERT_CYC  = 12;
    localparam int TOTAL_CYC    = SAMPLE_CYC + CONVERT_CYC;
    localparam logic [2:0] SRC_BANDGAP = 3'h1;
    localparam logic [2:0] SRC_GND_LO  = 3'h2;
    localparam logic [2:0] SRC_GND_HI  = 3'h4;
    typedef enum logic [2:0] {
        ADCSEQ_IDLE   = 3'b001,
        ADCSEQ_SAMPLE = 3'b010,
        ADCSEQ_CONV   = 3'b100
    } adcseq_state_t;
endpackage

/* core/adcseq_divider.sv */
// Purpose: A/D clock tick generator from pclk
// Assumes: code n gives one tick every 2**n pclk cycles
// Notes:   runs only while enabled
`timescale 1ns/100ps
module adcseq_divider (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic [2:0] code,
    output logic            tick
);
    typedef struct packed {
        logic [6:0] cnt;
        logic       tick;
    } adcseq_div_t;

    adcseq_div_t r_q;
    adcseq_div_t r_d;
    logic [6:0]  limit;

    // terminal count and next counter, cleared while stopped
    always_comb begin
        limit    = 7'((8'h01 << code) - 8'h01);
        r_d.cnt  = 7'h00;
        r_d.tick = 1'b0;
        if (run) begin
            if (r_q.cnt >= limit) begin
                r_d.tick = 1'b1;
            end else begin
                r_d.cnt = r_q.cnt + 7'h01;
            end
        end
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // tick straight from its flop
    assign tick = r_q.tick;
endmodule

/* core/adcseq_top.sv */
// Purpose: APB register file and sequencer for a 12-bit SAR converter
// Assumes: analog core gives a result word when conversion ends
// Notes:   zero-wait APB; pready is always high
`timescale 1ns/100ps
module adcseq_top #(
    parameter int SAMPLE_TICKS  = adcseq_pkg::SAMPLE_CYC,
    parameter int CONVERT_TICKS = adcseq_pkg::CONVERT_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [11:0] analog_result,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             converter_power,
    output logic             sample_hold,
    output logic             ext_channel_en,
    output logic      [2:0]  ext_channel,
    output logic             bandgap_sel,
    output logic             ground_sel,
    output logic      [1:0]  reference_source_sel
);
    typedef struct packed {
        // software controls, register a
        logic [3:0]                channel_sel;
        logic                      result_format_sel;
        logic                      converter_power_enable;
        logic                      start;
        logic                      armed;
        // software controls, register b
        logic [2:0]                adc_clock_divider_sel;
        logic [1:0]                reference_source_sel;
        logic [2:0]                input_source_sel;
        // interrupt flag and enables
        logic                      converter_interrupt_request;
        logic                      converter_interrupt_enable;
        logic                      global_interrupt_enable;
        // conversion state
        logic [11:0]               result;
        adcseq_pkg::adcseq_state_t state;
        logic [4:0]                count;
        // bus answer
        logic [31:0]               rdata;
        logic                      slverr;
        // registered outputs
        logic                      irq;
        logic                      sh;
        logic                      ext_en;
        logic                      bg;
        logic                      gnd;
    } adcseq_regs_t;

    localparam int TOTAL_TICKS = SAMPLE_TICKS + CONVERT_TICKS;

    adcseq_regs_t r_q;
    adcseq_regs_t r_d;
    logic         tick;
    logic         wr;
    logic         wr_setup;
    logic         rd;
    logic         busy;
    logic         run_d;

    // the five-bit tick counter must reach the last tick
    if (SAMPLE_TICKS < 1 || CONVERT_TICKS < 1 || TOTAL_TICKS > 32) begin : g_tick_range
        $error("adcseq_top: sample and convert tick counts out of range");
    end

    // bus phase decodes
    assign wr       = psel && penable && pwrite;
    assign wr_setup = psel && !penable && pwrite;
    assign rd       = psel && !penable && !pwrite;
    assign busy     = r_q.state != adcseq_pkg::ADCSEQ_IDLE;

    // divider starts at the launch edge, so no tick is lost to latency
    assign run_d    = (r_d.state != adcseq_pkg::ADCSEQ_IDLE) && r_d.converter_power_enable;

    // decode of an address into a mapped flag
    function automatic logic adcseq_mapped(input logic [11:0] a);
        adcseq_mapped = (a == adcseq_pkg::ADDR_CTRL_A) || (a == adcseq_pkg::ADDR_CTRL_B)
                     || (a == adcseq_pkg::ADDR_RES_HIGH) || (a == adcseq_pkg::ADDR_RES_LOW)
                     || (a == adcseq_pkg::ADDR_INT_STAT) || (a == adcseq_pkg::ADDR_INT_MASK);
    endfunction

    // aligned result bytes: format 1 right-justified, 0 left-justified
    function automatic logic [15:0] adcseq_align(input logic [11:0] v, input logic fmt);
        adcseq_align = fmt ? {4'h0, v} : {v, 4'h0};
    endfunction

    // input source decodes
    function automatic logic adcseq_src_bandgap(input logic [2:0] s);
        adcseq_src_bandgap = s == adcseq_pkg::SRC_BANDGAP;
    endfunction

    function automatic logic adcseq_src_ground(input logic [2:0] s);
        adcseq_src_ground = (s >= adcseq_pkg::SRC_GND_LO) && (s <= adcseq_pkg::SRC_GND_HI);
    endfunction

    function automatic logic adcseq_src_external(input logic [2:0] s);
        adcseq_src_external = !adcseq_src_bandgap(s) && !adcseq_src_ground(s);
    endfunction

    adcseq_divider u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (run_d),
        .code    (r_q.adc_clock_divider_sel),
        .tick    (tick)
    );

    // next-state of the whole block
    always_comb begin
        logic [15:0] al;
        logic        done;
        logic        launch;
        al     = adcseq_align(r_q.result, r_q.result_format_sel);
        done   = 1'b0;
        launch = 1'b0;
        r_d    = r_q;
        // error decided in setup, so it stands through the access phase
        r_d.slverr = wr_setup && !adcseq_mapped(paddr);

        // register writes
        if (wr) begin
            unique case (paddr)
                adcseq_pkg::ADDR_CTRL_A: begin
                    r_d.channel_sel            = pwdata[adcseq_pkg::CA_CHAN_LSB +: 4];
                    r_d.result_format_sel      = pwdata[adcseq_pkg::CA_FORMAT];
                    r_d.converter_power_enable = pwdata[adcseq_pkg::CA_POWER];
                    r_d.start                  = pwdata[adcseq_pkg::CA_START];
                end
                adcseq_pkg::ADDR_CTRL_B: begin
                    r_d.adc_clock_divider_sel = pwdata[adcseq_pkg::CB_DIV_LSB +: 3];
                    r_d.reference_source_sel  = pwdata[adcseq_pkg::CB_REF_LSB +: 2];
                    r_d.input_source_sel      = pwdata[adcseq_pkg::CB_SRC_LSB +: 3];
                end
                adcseq_pkg::ADDR_INT_MASK: begin
                    r_d.converter_interrupt_enable = pwdata[adcseq_pkg::IS_DONE];
                    r_d.global_interrupt_enable    = pwdata[adcseq_pkg::IS_GLOBAL];
                end
                adcseq_pkg::ADDR_INT_STAT: begin
                    if (pwdata[adcseq_pkg::IS_DONE]) begin
                        r_d.converter_interrupt_request = 1'b0;
                    end
                end
                default: begin
                    // result words are read only
                end
            endcase
        end

        // start edge: rising arms, falling launches
        if (r_d.start && !r_q.start) begin
            r_d.armed = 1'b1;
        end
        if (!r_d.start && r_q.start && r_q.armed) begin
            r_d.armed = 1'b0;
            launch    = r_q.converter_power_enable;
        end

        // sequencer counts A/D clock ticks, independent of the bus
        unique case (r_q.state)
            adcseq_pkg::ADCSEQ_IDLE: begin
            end
            adcseq_pkg::ADCSEQ_SAMPLE: begin
                if (tick) begin
                    r_d.count = r_q.count + 5'h01;
                    if (r_q.count == 5'(SAMPLE_TICKS - 1)) begin
                        r_d.state = adcseq_pkg::ADCSEQ_CONV;
                    end
                end
            end
            adcseq_pkg::ADCSEQ_CONV: begin
                if (tick) begin
                    r_d.count = r_q.count + 5'h01;
                    if (r_q.count == 5'(TOTAL_TICKS - 1)) begin
                        done = 1'b1;
                    end
                end
            end
            default: begin
                r_d.state = adcseq_pkg::ADCSEQ_IDLE;
            end
        endcase

        // a launch, also during a conversion but not on its last tick, restarts at the first sample
        if (launch) begin
            r_d.state = adcseq_pkg::ADCSEQ_SAMPLE;
            r_d.count = 5'h00;
        end

        // power off aborts
        if (!r_q.converter_power_enable) begin
            r_d.state = adcseq_pkg::ADCSEQ_IDLE;
        end
        if (done) begin
            r_d.state  = adcseq_pkg::ADCSEQ_IDLE;
            r_d.result = analog_result;
            r_d.converter_interrupt_request = 1'b1;
        end

        // read data, captured in setup phase
        r_d.rdata = 32'h0000_0000;
        if (rd) begin
            unique case (paddr)
                adcseq_pkg::ADDR_CTRL_A: begin
                    r_d.rdata[adcseq_pkg::CA_CHAN_LSB +: 4] = r_q.channel_sel;
                    r_d.rdata[adcseq_pkg::CA_FORMAT]        = r_q.result_format_sel;
                    r_d.rdata[adcseq_pkg::CA_POWER]         = r_q.converter_power_enable;
                    r_d.rdata[adcseq_pkg::CA_BUSY]          = busy;
                    r_d.rdata[adcseq_pkg::CA_START]         = r_q.start;
                end
                adcseq_pkg::ADDR_CTRL_B: begin
                    r_d.rdata[adcseq_pkg::CB_DIV_LSB +: 3] = r_q.adc_clock_divider_sel;
                    r_d.rdata[adcseq_pkg::CB_REF_LSB +: 2] = r_q.reference_source_sel;
                    r_d.rdata[adcseq_pkg::CB_SRC_LSB +: 3] = r_q.input_source_sel;
                end
                adcseq_pkg::ADDR_RES_HIGH: r_d.rdata[7:0] = al[15:8];
                adcseq_pkg::ADDR_RES_LOW:  r_d.rdata[7:0] = al[7:0];
                adcseq_pkg::ADDR_INT_STAT: begin
                    r_d.rdata[adcseq_pkg::IS_DONE] = r_q.converter_interrupt_request;
                end
                adcseq_pkg::ADDR_INT_MASK: begin
                    r_d.rdata[adcseq_pkg::IS_DONE]   = r_q.converter_interrupt_enable;
                    r_d.rdata[adcseq_pkg::IS_GLOBAL] = r_q.global_interrupt_enable;
                end
                default: begin
                    r_d.rdata = 32'h0000_0000;
                end
            endcase
        end else begin
            r_d.rdata = r_q.rdata;
        end

        // analog steering outputs, all open while unpowered
        r_d.sh     = 1'b0;
        r_d.bg     = 1'b0;
        r_d.gnd    = 1'b0;
        r_d.ext_en = 1'b0;
        if (r_d.converter_power_enable) begin
            r_d.sh     = r_d.state == adcseq_pkg::ADCSEQ_SAMPLE;
            r_d.bg     = adcseq_src_bandgap(r_d.input_source_sel);
            r_d.gnd    = adcseq_src_ground(r_d.input_source_sel);
            r_d.ext_en = adcseq_src_external(r_d.input_source_sel)
                      && !r_d.channel_sel[3];
        end

        // interrupt line, level while an enabled request stands
        r_d.irq = r_d.converter_interrupt_request && r_d.converter_interrupt_enable
               && r_d.global_interrupt_enable;
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '{state: adcseq_pkg::ADCSEQ_IDLE, default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    // prdata and pslverr straight from flops, pready tied high
    assign prdata               = r_q.rdata;
    assign pready               = 1'b1;
    assign pslverr              = r_q.slverr;

    // interrupt line
    assign irq                  = r_q.irq;

    // analog controls straight from flops
    assign converter_power      = r_q.converter_power_enable;
    assign sample_hold          = r_q.sh;
    assign ext_channel_en       = r_q.ext_en;
    assign ext_channel          = r_q.channel_sel[2:0];
    assign bandgap_sel          = r_q.bg;
    assign ground_sel           = r_q.gnd;
    assign reference_source_sel = r_q.reference_source_sel;
endmodule

/* verification/adcseq_monitor.sv */
// Purpose: port assertions for the conversion sequencer
// Assumes: zero-wait APB, divider codes 0 to 7
// Notes:   attached to adcseq_top by bind
`timescale 1ns/100ps
module adcseq_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        converter_power,
    input wire logic        sample_hold,
    input wire logic        ext_channel_en,
    input wire logic [2:0]  ext_channel,
    input wire logic        bandgap_sel,
    input wire logic        ground_sel,
    input wire logic [1:0]  reference_source_sel
);
    // single clock domain
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // bus answers at once, errors only on writes
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err; pslverr |-> psel && penable && pwrite; endproperty
    a_err: assert property (p_err) else $error("pslverr outside write access");
    // power off leaves every input path open
    property p_off; !converter_power [*2] |-> !(sample_hold || ext_channel_en || bandgap_sel || ground_sel); endproperty
    a_off: assert property (p_off) else $error("path active while unpowered");
    property p_src; $onehot0({ext_channel_en, bandgap_sel, ground_sel}); endproperty
    a_src: assert property (p_src) else $error("two input paths at once");
    // sampling window length
    property p_shmin; $rose(sample_hold) |-> (sample_hold || !converter_power) [*4]; endproperty
    a_shmin: assert property (p_shmin) else $error("sampling too short");
    property p_shmax; $rose(sample_hold) |-> ##[1:512] !sample_hold; endproperty
    a_shmax: assert property (p_shmax) else $error("sampling too long");
    // routing changes only by register writes
    property p_ref; !$stable(reference_source_sel) |-> $past(psel && penable && pwrite && paddr == 12'h004); endproperty
    a_ref: assert property (p_ref) else $error("reference changed without write");
    property p_chan; !$stable(ext_channel) |-> $past(psel && penable && pwrite && paddr == 12'h000); endproperty
    a_chan: assert property (p_chan) else $error("channel changed without write");
endmodule
bind adcseq_top adcseq_monitor adcseq_monitor_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
    .pslverr, .converter_power, .sample_hold, .ext_channel_en, .ext_channel, .bandgap_sel, .ground_sel,
    .reference_source_sel);

/* verification/tb.sv */
// Purpose: self-checking bench for the conversion sequencer
// Assumes: zero-wait APB, map from the package
// Notes:   random channel, format and result with fixed seed
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
module tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 12'h000, analog_result = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, irq, converter_power, sample_hold, ext_channel_en, bandgap_sel, ground_sel;
    logic [2:0]  ext_channel;
    logic [1:0]  reference_source_sel;
    int          fail_count = 0, checks = 0, cyc = 0, shc = 0, t0;
    adcseq_top adcseq_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .analog_result,
        .prdata, .pready, .pslverr, .irq, .converter_power, .sample_hold, .ext_channel_en, .ext_channel,
        .bandgap_sel, .ground_sel, .reference_source_sel);
    // clock, cycle and sampling counters
    initial forever #4 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (sample_hold === 1'h1) shc++;
    end
    // one APB transfer, then an idle edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    // expected result bytes: format 1 right-justified, 0 left-justified
    function automatic logic [15:0] exp_align(input logic [11:0] v, input logic f);
        return f ? {4'h0, v} : {v, 4'h0};
    endfunction
    task automatic end_sim;
        if (fail_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        end_sim;
    end
    // main sequence
    initial begin
        logic [3:0]  ch;
        logic        f;
        logic [1:0]  m, rf;
        logic [15:0] e;
        rd = $urandom(51);
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        for (int a = 0; a < 6; a++) begin
            apb(0, 12'(a * 4), 0);
            `CHK("reset_reg", 32'h0, rd)
        end
        apb(1, 12'h020, 32'hFFFFFFFF);
        `CHK("unmapped_err", 1'h1, err)
        apb(1, adcseq_pkg::ADDR_CTRL_A, 32'hC0);
        apb(1, adcseq_pkg::ADDR_CTRL_A, 32'h40);
        apb(0, adcseq_pkg::ADDR_CTRL_A, 0);
        `CHK("busy_unpowered", 1'h0, rd[6])
        for (int s = 0; s < 8; s++) begin
            ch = 4'($urandom);
            if (s >= 1 && s <= 4) ch[3] = 1'h1;
            apb(1, adcseq_pkg::ADDR_CTRL_A, {26'h0, 2'h2, ch});
            `CHK("power_on", 1'h1, converter_power)
            apb(1, adcseq_pkg::ADDR_CTRL_B, {24'h0, 3'(s), 5'h0});
            `CHK("bandgap", s == 1, bandgap_sel)
            `CHK("ground", s >= 2 && s <= 4, ground_sel)
            `CHK("ext_en", (s == 0 || s > 4) && !ch[3], ext_channel_en)
            `CHK("ext_ch", ch[2:0], ext_channel)
        end
        for (int c = 0; c < 8; c++) begin
            ch = 4'($urandom);
            f = 1'($urandom);
            m = 2'(c);
            rf = 2'($urandom);
            analog_result <= (c == 7) ? 12'hFFF : 12'($urandom);
            apb(1, adcseq_pkg::ADDR_INT_MASK, {30'h0, m});
            apb(1, adcseq_pkg::ADDR_CTRL_B, {27'h0, rf, 3'(c)});
            `CHK("ref_sel", rf, reference_source_sel)
            apb(1, adcseq_pkg::ADDR_CTRL_A, {24'h0, 3'h5, f, ch});
            shc = 0;
            apb(1, adcseq_pkg::ADDR_CTRL_A, {24'h0, 3'h1, f, ch});
            t0 = cyc;
            apb(0, adcseq_pkg::ADDR_CTRL_A, 0);
            `CHK("busy_set", 1'h1, rd[6])
            while (rd[6] === 1'h1 && cyc - t0 < 5000) apb(0, adcseq_pkg::ADDR_CTRL_A, 0);
            `CHK("conv_len", 1'h1, cyc - t0 >= (16 << c) - 2 && cyc - t0 <= (16 << c) + 8)
            `CHK("sample_len", 4 << c, shc)
            apb(0, adcseq_pkg::ADDR_INT_STAT, 0);
            `CHK("done_flag", 32'h1, rd)
            `CHK("irq_level", &m, irq)
            e = exp_align(analog_result, f);
            apb(0, adcseq_pkg::ADDR_RES_HIGH, 0);
            `CHK("res_high", {24'h0, e[15:8]}, rd)
            apb(0, adcseq_pkg::ADDR_RES_LOW, 0);
            `CHK("res_low", {24'h0, e[7:0]}, rd)
            apb(1, adcseq_pkg::ADDR_INT_STAT, 32'h1);
            `CHK("irq_clear", 1'h0, irq)
        end
        apb(1, adcseq_pkg::ADDR_CTRL_A, 32'hA0);
        apb(1, adcseq_pkg::ADDR_CTRL_A, 32'h20);
        repeat (20) @(posedge pclk);
        apb(1, adcseq_pkg::ADDR_CTRL_A, 32'h00);
        `CHK("power_off", 1'h0, converter_power)
        `CHK("abort_sample", 1'h0, sample_hold)
        apb(0, adcseq_pkg::ADDR_CTRL_A, 0);
        `CHK("abort_busy", 1'h0, rd[6])
        apb(0, adcseq_pkg::ADDR_INT_STAT, 0);
        `CHK("abort_flag", 32'h0, rd)
        end_sim;
    end
endmodule
